// File: design/dpram_host_pkg.sv
// constants and carrier types for the dual-port memory host controller
package dpram_host_pkg;

  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 18;
  localparam int LANE_W    = 2;
  localparam int SEM_SEL_W = 3;
  localparam int DEV_N     = 2;
  localparam int CNT_W     = 3;

  // timing, in ns as given for the memory, then in 50 ns clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_SETTLE_NS = 15;
  localparam int WRITE_PULSE_NS = 15;
  localparam int BUSY_SYNC_LAT  = 1;

  // least time, rounded up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  localparam int BUSY_SETTLE_CYC = ns_to_cycles(BUSY_SETTLE_NS);
  localparam int WRITE_PULSE_CYC = ns_to_cycles(WRITE_PULSE_NS);
  localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(BUSY_SETTLE_CYC + BUSY_SYNC_LAT - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(WRITE_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 3'h0;

  // mailbox words, full and reduced depth variants
  localparam logic [ADDR_W-1:0] MBOX_LEFT_FULL   = 19'h7FFFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_FULL  = 19'h7FFFF;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_SMALL  = 19'h3FFFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_SMALL = 19'h3FFFF;
  localparam logic [ADDR_W-1:0] SMALL_ADDR_MASK  = 19'h3FFFF;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [LANE_W-1:0] LANE_OFF_N = 2'h3;

  typedef enum logic [3:0] {
    OP_READ      = 4'b0001,
    OP_WRITE     = 4'b0010,
    OP_TOKEN_RD  = 4'b0100,
    OP_TOKEN_WR  = 4'b1000
  } op_e;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_FINISH = 4'b1000
  } state_e;

  typedef struct packed {
    op_e               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANE_W-1:0] lanes_n;
  } cmd_s;

  // pins that the host drives toward the memory port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              array_select_low_n;
    logic              array_select_high;
    logic              token_space_select_n;
    logic              rw_n;
    logic              oe_n;
    logic [LANE_W-1:0] byte_lane_enable_n;
    logic [DATA_W-1:0] data;
    logic              data_oe;
  } pins_s;

  localparam pins_s PINS_IDLE = '{
    addr: ADDR_RESET, array_select_low_n: 1'b1, array_select_high: 1'b0,
    token_space_select_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
    byte_lane_enable_n: LANE_OFF_N, data: DATA_RESET, data_oe: 1'b0};

endpackage

// File: design/busy_merge.sv
// registered AND of the collision flags of depth-stacked memories
`timescale 1ns/10ps
module busy_merge (
  input  wire logic                           clk_i,
  input  wire logic                           reset_i,
  input  wire logic [dpram_host_pkg::DEV_N-1:0] busy_n_i,
  output logic                                busy_n_o
);

  typedef struct packed {
    logic busy_n;
  } merge_s;

  merge_s state_reg;
  merge_s state_next;

  // any device low makes the array busy
  always_comb begin
    state_next        = state_reg;
    state_next.busy_n = &busy_n_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg.busy_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy_n_o = state_reg.busy_n;

endmodule

// File: design/dpram_host.sv
// host controller for one port of the dual-port memory with tokens and mailbox
`timescale 1ns/10ps

module dpram_host #(
  parameter bit RIGHT_PORT  = 1'b0,
  parameter bit SMALL_DEPTH = 1'b0
) (
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  input  wire logic                              req_i,
  input  wire dpram_host_pkg::cmd_s              cmd_i,
  output logic                                   ready_o,
  output logic                                   done_o,
  output logic [dpram_host_pkg::DATA_W-1:0]      rdata_o,
  output logic                                   collided_o,
  output logic                                   mailbox_pending_o,
  output dpram_host_pkg::pins_s                  pins_o,
  input  wire logic [dpram_host_pkg::DATA_W-1:0] data_i,
  input  wire logic [dpram_host_pkg::DEV_N-1:0]  collision_flag_n_i,
  input  wire logic                              mailbox_flag_n_i
);

  // every register of the controller lives in this one struct, except the merged busy flag held in busy_merge
  typedef struct packed {
    dpram_host_pkg::state_e              st;
    logic [dpram_host_pkg::CNT_W-1:0]    cnt;
    dpram_host_pkg::cmd_s                cmd;
    logic                                init_pending;
    logic                                internal;
    logic                                ready;
    logic                                done;
    logic [dpram_host_pkg::DATA_W-1:0]   rdata;
    logic                                collided;
    logic                                mbox_pending;
    dpram_host_pkg::pins_s               pins;
  } host_s;

  // registered state, its next value and the merged collision flag
  host_s state_reg;
  host_s state_next;
  logic  busy_n;

  // own mailbox word, chosen by port side and depth variant
  localparam logic [dpram_host_pkg::ADDR_W-1:0] OWN_MBOX =
    SMALL_DEPTH ? (RIGHT_PORT ? dpram_host_pkg::MBOX_RIGHT_SMALL : dpram_host_pkg::MBOX_LEFT_SMALL)
                : (RIGHT_PORT ? dpram_host_pkg::MBOX_RIGHT_FULL  : dpram_host_pkg::MBOX_LEFT_FULL);

  // token ops go to the semaphore space, everything else to the array
  function automatic logic is_token(input dpram_host_pkg::op_e op);
    return (op == dpram_host_pkg::OP_TOKEN_RD) || (op == dpram_host_pkg::OP_TOKEN_WR);
  endfunction

  // array and token writes both pulse the write strobe
  function automatic logic is_write(input dpram_host_pkg::op_e op);
    return (op == dpram_host_pkg::OP_WRITE) || (op == dpram_host_pkg::OP_TOKEN_WR);
  endfunction

  // one master per width group drives each flag, so all slices stall together
  busy_merge u_busy_merge (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .busy_n_i (collision_flag_n_i),
    .busy_n_o (busy_n)
  );

  // one access: select and settle, strobe, release
  always_comb begin
    state_next              = state_reg;
    state_next.done         = 1'b0;
    state_next.mbox_pending = ~mailbox_flag_n_i; // flag is active low
    unique case (state_reg.st)
      // idle: pins quiet, reset-time mailbox read beats any user request
      dpram_host_pkg::ST_IDLE: begin
        state_next.pins = dpram_host_pkg::PINS_IDLE;
        if (state_reg.init_pending) begin
          // clear own mailbox flag once after reset by reading the word
          state_next.cmd.op      = dpram_host_pkg::OP_READ;
          state_next.cmd.addr    = OWN_MBOX;
          state_next.cmd.wdata   = dpram_host_pkg::DATA_RESET;
          state_next.cmd.lanes_n = 2'h0;
          state_next.internal    = 1'b1;
          state_next.init_pending = 1'b0;
          state_next.ready       = 1'b0;
          state_next.st          = dpram_host_pkg::ST_SETUP;
        end else if (req_i) begin
          state_next.cmd         = cmd_i;
          state_next.internal    = 1'b0;
          state_next.ready       = 1'b0;
          state_next.st          = dpram_host_pkg::ST_SETUP;
        end
        // drive selects and address from the command just latched
        if (state_next.st == dpram_host_pkg::ST_SETUP) begin
          state_next.collided = 1'b0;
          state_next.cnt      = dpram_host_pkg::SETUP_LOAD;
          state_next.pins.byte_lane_enable_n = state_next.cmd.lanes_n;
          if (is_token(state_next.cmd.op)) begin
            state_next.pins.array_select_low_n   = 1'b1;
            state_next.pins.array_select_high    = 1'b0;
            state_next.pins.token_space_select_n = 1'b0;
            // only the three low bits pick one of eight tokens
            state_next.pins.addr = {16'h0000, state_next.cmd.addr[dpram_host_pkg::SEM_SEL_W-1:0]};
          end else begin
            state_next.pins.array_select_low_n = 1'b0;
            state_next.pins.array_select_high  = 1'b1;
            state_next.pins.addr = SMALL_DEPTH ? (state_next.cmd.addr & dpram_host_pkg::SMALL_ADDR_MASK)
                                               : state_next.cmd.addr;
          end
        end
      end

      // setup: selects and address stand while the flag settles
      dpram_host_pkg::ST_SETUP: begin
        // busy only has meaning for array accesses
        if (!busy_n && !is_token(state_reg.cmd.op)) begin
          state_next.collided = 1'b1;
        end
        if (state_reg.cnt != dpram_host_pkg::CNT_ZERO) begin
          state_next.cnt = state_reg.cnt - 3'h1;
        end else if (is_write(state_reg.cmd.op) && !is_token(state_reg.cmd.op) && !busy_n) begin
          // a write pulse now would be discarded, so hold selects and wait
          state_next.cnt = dpram_host_pkg::CNT_ZERO;
        end else begin
          state_next.cnt = dpram_host_pkg::PULSE_LOAD;
          state_next.st  = dpram_host_pkg::ST_STROBE;
          if (is_write(state_reg.cmd.op)) begin
            state_next.pins.rw_n    = 1'b0;
            state_next.pins.data_oe = 1'b1;
            // a token takes bit 0; repeating it keeps the bus quiet
            state_next.pins.data = is_token(state_reg.cmd.op) ? {dpram_host_pkg::DATA_W{state_reg.cmd.wdata[0]}}
                                                               : state_reg.cmd.wdata;
          end else begin
            state_next.pins.oe_n = 1'b0;
          end
        end
      end

      // strobe: read or write pulse for the pulse count
      dpram_host_pkg::ST_STROBE: begin
        if (state_reg.cnt != dpram_host_pkg::CNT_ZERO) begin
          state_next.cnt = state_reg.cnt - 3'h1;
        end else begin
          if (!is_write(state_reg.cmd.op)) begin
            state_next.rdata = data_i;
          end
          // end strobe and selects first; data is held one more cycle
          state_next.pins.rw_n                 = 1'b1;
          state_next.pins.oe_n                 = 1'b1;
          state_next.pins.array_select_low_n   = 1'b1;
          state_next.pins.array_select_high    = 1'b0;
          state_next.pins.token_space_select_n = 1'b1;
          state_next.st = dpram_host_pkg::ST_FINISH;
        end
      end

      // finish: data released one cycle after the strobe ends
      dpram_host_pkg::ST_FINISH: begin
        state_next.pins  = dpram_host_pkg::PINS_IDLE;
        state_next.done  = ~state_reg.internal;
        state_next.ready = 1'b1;
        state_next.st    = dpram_host_pkg::ST_IDLE;
      end
      // illegal one-hot code: back to idle with pins quiet
      default: begin
        state_next.pins = dpram_host_pkg::PINS_IDLE;
        state_next.st   = dpram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // synchronous reset, every field to a constant
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg.st           <= dpram_host_pkg::ST_IDLE;
      state_reg.cnt          <= dpram_host_pkg::CNT_ZERO;
      state_reg.cmd          <= '{op: dpram_host_pkg::OP_READ, addr: dpram_host_pkg::ADDR_RESET,
                                  wdata: dpram_host_pkg::DATA_RESET, lanes_n: dpram_host_pkg::LANE_OFF_N};
      state_reg.init_pending <= 1'b1;
      state_reg.internal     <= 1'b0;
      state_reg.ready        <= 1'b0;
      state_reg.done         <= 1'b0;
      state_reg.rdata        <= dpram_host_pkg::DATA_RESET;
      state_reg.collided     <= 1'b0;
      state_reg.mbox_pending <= 1'b0;
      state_reg.pins         <= dpram_host_pkg::PINS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output straight from the state register
  assign ready_o           = state_reg.ready;
  assign done_o            = state_reg.done;
  assign rdata_o           = state_reg.rdata;
  assign collided_o        = state_reg.collided;
  assign mailbox_pending_o = state_reg.mbox_pending;
  assign pins_o            = state_reg.pins;

endmodule

// File: verification/dpram_host_properties.sv
// concurrent checks on the memory-side pins of the port controller
`timescale 1ns/10ps
module dpram_host_properties #(
  parameter bit RIGHT_PORT  = 1'b0,
  parameter bit SMALL_DEPTH = 1'b0
) (
  input wire logic                             clk_i,
  input wire logic                             reset_i,
  input wire dpram_host_pkg::pins_s            pins_o,
  input wire logic [dpram_host_pkg::DEV_N-1:0] collision_flag_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // own mailbox word, which the host must read once after reset
  localparam logic [18:0] MBOX = SMALL_DEPTH ? (RIGHT_PORT ? 19'h3FFFF : 19'h3FFFE)
                                             : (RIGHT_PORT ? 19'h7FFFF : 19'h7FFFE);
  logic arr;
  logic tok;
  // decoded select states
  assign arr = !pins_o.array_select_low_n && pins_o.array_select_high;
  assign tok = !pins_o.token_space_select_n;

  a_token_space_only: assert property (tok |-> pins_o.array_select_low_n && !pins_o.array_select_high)
    else $error("token select while array selected");
  a_pulse_in_select: assert property (!pins_o.rw_n |-> arr || tok)
    else $error("write pulse without a select");
  a_write_setup_held: assert property ($fell(pins_o.rw_n) && arr |-> $past(arr, 2) && $past(pins_o.addr, 2) == pins_o.addr)
    else $error("write pulse before address settled");
  a_merged_busy_gate: assert property ($fell(pins_o.rw_n) && arr |-> $past(&collision_flag_n_i, 2))
    else $error("write pulse while a stacked flag was low");
  a_mailbox_init_read: assert property ($fell(reset_i) |-> ##[1:8] (arr && !pins_o.oe_n && pins_o.addr == MBOX))
    else $error("no mailbox read after reset");
  a_reset_pins_idle: assert property (@(posedge clk_i) disable iff (1'b0) reset_i |=> pins_o == dpram_host_pkg::PINS_IDLE)
    else $error("pins not idle during reset");
endmodule
bind dpram_host dpram_host_properties #(.RIGHT_PORT(RIGHT_PORT), .SMALL_DEPTH(SMALL_DEPTH)) dpram_host_properties_inst (
  .clk_i(clk_i), .reset_i(reset_i), .pins_o(pins_o), .collision_flag_n_i(collision_flag_n_i));

// File: verification/dpram_port_model.sv
// behavioural left memory port: array, collision flag, tokens, mailbox flag
`timescale 1ns/10ps
module dpram_port_model (
  input  wire dpram_host_pkg::pins_s pins_i,
  input  wire logic [18:0]           other_addr_i,
  input  wire logic                  other_sel_i,
  input  wire logic                  stack_busy_n_i,
  output logic [17:0]                data_o,
  output logic [1:0]                 busy_n_o,
  output logic                       mbox_n_o
);
  logic [17:0] mem [int];
  logic [17:0] last, tok_q, val;
  logic [7:0]  hold [2], pend [2]; // side 0 host port, side 1 far port
  logic        sel, tok, drv, ot_first;
  // array and token space decode
  assign sel = !pins_i.array_select_low_n && pins_i.array_select_high && pins_i.token_space_select_n;
  assign tok = pins_i.array_select_low_n && !pins_i.array_select_high && !pins_i.token_space_select_n;
  // the port that settled later loses; read or write does not matter
  always @(posedge sel) ot_first = other_sel_i;
  assign busy_n_o[0] = !(sel && other_sel_i && ot_first && pins_i.addr == other_addr_i);
  assign busy_n_o[1] = stack_busy_n_i;
  // released or lane-disabled bus shows the inverse of its last value, so stale data cannot pass
  assign drv = !pins_i.oe_n && (sel || tok) && pins_i.byte_lane_enable_n != 2'h3;
  assign data_o = drv ? val : ~last;
  always @(val or drv) if (drv) last = val;
  always @(pins_i or tok_q) begin
    if (!pins_i.token_space_select_n) val = tok_q;
    else if (mem.exists(int'(pins_i.addr))) val = mem[int'(pins_i.addr)];
    else val = 18'h0;
  end
  // token latches; a zero on a held token waits in the request latch
  task automatic tok_wr(input int s, input int i, input logic d);
    if (!d && !hold[1-s][i]) hold[s][i] = 1'b1;
    else if (!d) pend[s][i] = 1'b1;
    else begin
      if (hold[s][i]) begin
        hold[s][i] = 1'b0;
        hold[1-s][i] = pend[1-s][i];
        pend[1-s][i] = 1'b0;
      end
      pend[s][i] = 1'b0;
    end
  endtask
  task automatic set_mbox();
    mbox_n_o = 1'b0;
  endtask
  // writes land at pulse start; a lost arbitration drops them, an undriven bus stores the inverse
  always @(negedge pins_i.rw_n) begin
    if (sel && busy_n_o[0]) mem[int'(pins_i.addr)] = pins_i.data_oe ? pins_i.data : ~pins_i.data;
    if (tok) tok_wr(0, int'(pins_i.addr[2:0]), pins_i.data_oe ? pins_i.data[0] : ~pins_i.data[0]);
  end
  // token value frozen when the read starts; mailbox word read clears the flag
  always @(negedge pins_i.oe_n) begin
    if (tok) tok_q = {18{!hold[0][pins_i.addr[2:0]]}};
    if (sel && pins_i.addr == 19'h7FFFE) mbox_n_o = 1'b1;
  end
  // flag left asserted at power-up so the host must clear it
  initial begin
    hold = '{8'h00, 8'h00};
    pend = '{8'h00, 8'h00};
    mbox_n_o = 1'b0;
    last = 18'h0;
    tok_q = 18'h3FFFF;
  end
endmodule

// File: verification/tb.sv
// self-checking bench: port controller against the memory port model
`timescale 1ns/10ps
module tb;
  logic                  clk_i, reset_i, req_i, other_sel, stack_busy_n;
  logic                  ready, done, collided, pending, mbox_n;
  logic [17:0]           rdata, data;
  logic [18:0]           other_addr;
  logic [1:0]            busy_n;
  dpram_host_pkg::cmd_s  cmd_i;
  dpram_host_pkg::pins_s pins;
  int                    error_cnt, compares;

  dpram_host dpram_host_inst (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .cmd_i(cmd_i), .ready_o(ready),
    .done_o(done), .rdata_o(rdata), .collided_o(collided), .mailbox_pending_o(pending), .pins_o(pins),
    .data_i(data), .collision_flag_n_i(busy_n), .mailbox_flag_n_i(mbox_n));
  dpram_port_model dpram_port_model_inst (.pins_i(pins), .other_addr_i(other_addr), .other_sel_i(other_sel),
    .stack_busy_n_i(stack_busy_n), .data_o(data), .busy_n_o(busy_n), .mbox_n_o(mbox_n));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait, sampled at the falling edge away from launches
  task automatic wait_hi(input bit on_done);
    int n;
    n = 0;
    while ((on_done ? done : ready) !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 200) begin
        error_cnt++;
        $display("ERROR handshake expected 1 seen timeout");
        test_done();
      end
    end
  endtask

  task automatic issue(input dpram_host_pkg::op_e op, input logic [18:0] a, input logic [17:0] d);
    wait_hi(1'b0);
    @(posedge clk_i);
    req_i <= 1'b1;
    cmd_i <= '{op: op, addr: a, wdata: d, lanes_n: 2'h0};
    @(posedge clk_i);
    req_i <= 1'b0;
  endtask

  task automatic access(input dpram_host_pkg::op_e op, input logic [18:0] a, input logic [17:0] d);
    issue(op, a, d);
    wait_hi(1'b1);
  endtask

  task automatic mailbox_check();
    dpram_port_model_inst.set_mbox();
    repeat (2) @(negedge clk_i);
    chk("mailbox raised", 18'h1, {17'h0, pending});
    access(dpram_host_pkg::OP_READ, 19'h7FFFE, 18'h0);
    repeat (2) @(negedge clk_i);
    chk("mailbox cleared", 18'h0, {17'h0, pending});
  endtask

  task automatic storage_check();
    logic [18:0] a [3] = '{19'h7FFFE, 19'h7FFFF, 19'h00400};
    foreach (a[i]) access(dpram_host_pkg::OP_WRITE, a[i], 18'h3C0F0 ^ 18'(i));
    foreach (a[i]) begin
      access(dpram_host_pkg::OP_READ, a[i], 18'h0);
      chk("stored word", 18'h3C0F0 ^ 18'(i), rdata);
    end
  endtask

  // steps are {far side writes, value written, flag the host then reads}
  task automatic token_check();
    logic [2:0] steps [6] = '{3'b000, 3'b100, 3'b011, 3'b001, 3'b110, 3'b011};
    logic [18:0] a;
    for (int k = 0; k < 2; k++) begin
      a = 19'h55550 | 19'(k * 7);
      access(dpram_host_pkg::OP_TOKEN_RD, a, 18'h0);
      chk("token free", 18'h3FFFF, rdata);
      foreach (steps[s]) begin
        if (steps[s][2]) dpram_port_model_inst.tok_wr(1, k * 7, steps[s][1]);
        else access(dpram_host_pkg::OP_TOKEN_WR, a, {17'h0, steps[s][1]});
        access(dpram_host_pkg::OP_TOKEN_RD, a, 18'h0);
        chk("token flag", {18{steps[s][0]}}, rdata);
      end
    end
  endtask

  task automatic collision_check();
    @(posedge clk_i);
    other_addr <= 19'h01234;
    other_sel <= 1'b1;
    issue(dpram_host_pkg::OP_WRITE, 19'h01234, 18'h2A5A5);
    repeat (6) @(negedge clk_i);
    chk("stalled write ready", 18'h0, {17'h0, ready});
    @(posedge clk_i);
    other_sel <= 1'b0;
    wait_hi(1'b1);
    chk("collision seen", 18'h1, {17'h0, collided});
    access(dpram_host_pkg::OP_READ, 19'h01234, 18'h0);
    chk("write after stall", 18'h2A5A5, rdata);
    @(posedge clk_i);
    stack_busy_n <= 1'b0;
    access(dpram_host_pkg::OP_READ, 19'h00400, 18'h0);
    chk("stacked busy seen", 18'h1, {17'h0, collided});
    @(posedge clk_i);
    stack_busy_n <= 1'b1;
  endtask

  initial begin
    reset_i = 1'b1;
    req_i = 1'b0;
    cmd_i = '0;
    other_sel = 1'b0;
    other_addr = 19'h0;
    stack_busy_n = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    wait_hi(1'b0);
    chk("mailbox after reset", 18'h0, {17'h0, pending});
    mailbox_check();
    storage_check();
    token_check();
    collision_check();
    test_done();
  end
endmodule
